// File: src/csba_core.sv
// Purpose: execute unsigned compare-skip and decimal adjust
// Assumes: sys_clk 100 MHz, four phases per instruction cycle
// Notes: datapath values arrive as inputs, results leave as strobes
// Notes on behaviour
// RL1 - a word whose top seven bits are 0110010 is compare_skip_if_greater.
// RL2 - greater compare is unsigned and squashes the next word if f > W.
// RL3 - a word whose top seven bits are 0110000 is compare_skip_if_less.
// RL4 - less compare is unsigned and squashes the next word if f < W.
// RL5 - neither compare ever writes a status flag.
// RL6 - a compare is one word, one cycle, or two when it skips.
// RL7 - a skip over a two-word instruction takes three cycles in all.
// RL8 - a skipped cycle writes nothing in any phase.
// RL9 - bank bit zero picks the access bank, one picks the bank register.
// RL10 - greater compare uses indexed offset for a=0, ext on, f <= 95.
// RL11 - decimal adjust adds 6 to the low nibble if above 9 or digit carry.
// RL12 - high nibble becomes hi+dc+6 if hi+dc above 9 or carry, else hi+dc.
// RL13 - decimal adjust has no operand and works on W in one cycle.
// RL14 - decimal adjust sets carry on high overflow and keeps a set carry.
// RL15 - the skip is decided in the compare cycle, before any later write.
`timescale 1ns/1ps
`include "csba_regs.svh"
module csba_core (
	input wire logic sys_clk, // core clock
	input wire logic sys_rst, // async reset, high
	input wire csba_pkg::csba_apb_req_t apb_req, // apb request
	output csba_pkg::csba_apb_rsp_t apb_rsp, // apb answer
	input wire logic instr_valid, // fetched word present in q1
	input wire logic [15:0] instr_word, // fetched word
	input wire logic next_two_word, // prefetched word is two-word
	input wire logic [7:0] working_register, // current W
	input wire logic carry_in, // current carry flag
	input wire logic digit_carry_flag, // current digit carry
	input wire logic [11:0] index_base, // index pointer base
	input wire logic [7:0] file_rdata, // file byte, valid in q2
	output logic [3:0] phase, // one-hot current phase
	output logic [11:0] file_addr, // file address in q2
	output logic file_rd, // file read strobe in q2
	output logic [7:0] working_register_wdata, // new W value
	output logic working_register_we, // W write in q4
	output logic carry_wdata, // new carry value
	output logic carry_we, // carry write in q4
	output logic squash // current cycle is discarded
);
	import csba_pkg::*;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	csba_phase_t ph;
	csba_op_t op;
	logic [7:0] operand;
	logic [1:0] skip_left;
	logic skip_taken;
	logic ext_en;
	logic [3:0] bank_select_register;
	logic [7:0] last_w;
	logic [11:0] next_addr;
	logic cmp_gt;
	logic cmp_lt;
	logic [3:0] lo;
	logic [4:0] hi_sum;
	logic [4:0] hi_fix;
	logic [7:0] adj_w;
	logic adj_c;
	csba_op_t next_op;
	logic [31:0] rd_word;
	logic rd_ok;
	logic acc;
	logic wr_hit;

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	// only the three opcodes this unit owns; all else is NONE
	always_comb begin
		next_op = CSBA_NONE;
		if (instr_word[15:9] == `CSBA_OP_GT) begin
			next_op = CSBA_GT; // RL1
		end else if (instr_word[15:9] == `CSBA_OP_LT) begin
			next_op = CSBA_LT; // RL3
		end else if (instr_word == `CSBA_OP_DAW) begin
			next_op = CSBA_DAW; // RL13
		end
	end

	// ----------------------------------------------------------------
	// operand address
	// ----------------------------------------------------------------
	// bit 8 is the bank bit, bits 7:0 the file address
	// taken from the fetched word so the address stands for all of q2
	always_comb begin
		if (instr_word[8]) begin
			next_addr = {bank_select_register, instr_word[7:0]}; // RL9
		end else if (next_op == CSBA_GT && ext_en &&
			instr_word[7:0] <= `CSBA_IDX_MAX) begin
			// indexed offset wraps inside the 12-bit space
			next_addr = index_base + {4'h0, instr_word[7:0]}; // RL10
		end else if (instr_word[7:0] < `CSBA_ACC_SPLIT) begin
			next_addr = {4'h0, instr_word[7:0]}; // RL9
		end else begin
			next_addr = {`CSBA_ACC_HIGH, instr_word[7:0]}; // RL9
		end
	end

	// ----------------------------------------------------------------
	// compare and decimal adjust
	// ----------------------------------------------------------------
	// plain 8-bit magnitude compare, no sign
	assign cmp_gt = operand > working_register; // RL2
	assign cmp_lt = operand < working_register; // RL4

	// nibble corrections kept separate, no low carry into high
	always_comb begin
		lo = working_register[3:0];
		if (working_register[3:0] > `CSBA_LO_MAX ||
			digit_carry_flag) begin
			lo = working_register[3:0] + `CSBA_LO_FIX; // RL11
		end
		hi_sum = {1'b0, working_register[7:4]} +
			{4'h0, digit_carry_flag}; // RL12
		hi_fix = hi_sum;
		if (hi_sum > `CSBA_BCD_MAX || carry_in) begin
			hi_fix = hi_sum + `CSBA_BCD_FIX; // RL12
		end
		adj_w = {hi_fix[3:0], lo};
		adj_c = carry_in | hi_fix[4]; // RL14
	end

	// ----------------------------------------------------------------
	// phase sequencer
	// ----------------------------------------------------------------
	// free running q1..q4, one instruction cycle per turn
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ph <= CSBA_Q1;
		end else begin
			case (ph)
			CSBA_Q1: ph <= CSBA_Q2;
			CSBA_Q2: ph <= CSBA_Q3;
			CSBA_Q3: ph <= CSBA_Q4;
			CSBA_Q4: ph <= CSBA_Q1;
			default: ph <= CSBA_Q1;
			endcase
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			phase <= 4'b0001;
		end else begin
			// mirrors the next sequencer state, so port equals ph
			case (ph)
			CSBA_Q1: phase <= CSBA_Q2;
			CSBA_Q2: phase <= CSBA_Q3;
			CSBA_Q3: phase <= CSBA_Q4;
			CSBA_Q4: phase <= CSBA_Q1;
			default: phase <= CSBA_Q1;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// instruction latch and operand read
	// ----------------------------------------------------------------
	// a squashed cycle never latches its word, so it does nothing
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			op <= CSBA_NONE;
		end else if (ph == CSBA_Q1) begin
			if (instr_valid && !squash) begin // RL8
				op <= next_op;
			end else begin
				op <= CSBA_NONE; // RL8
			end
		end else if (ph == CSBA_Q4) begin
			op <= CSBA_NONE;
		end
	end

	// address out for all of q2, byte caught at the end of q2
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			file_addr <= 12'h000;
			file_rd <= 1'b0;
			operand <= 8'h00;
		end else begin
			case (ph)
			CSBA_Q1: begin
				file_rd <= 1'b0;
			end
			CSBA_Q2: begin
				file_rd <= 1'b0;
				if (op == CSBA_GT || op == CSBA_LT) begin
					operand <= file_rdata; // RL6
				end
			end
			CSBA_Q4: begin
				file_rd <= 1'b0;
			end
			default: begin
				file_rd <= 1'b0;
			end
			endcase
			// drive the address one edge ahead of q2
			if (ph == CSBA_Q1 && instr_valid && !squash &&
				(next_op == CSBA_GT || next_op == CSBA_LT)) begin
				file_rd <= 1'b1;
				file_addr <= next_addr; // RL9 RL10
			end
		end
	end

	// ----------------------------------------------------------------
	// skip control
	// ----------------------------------------------------------------
	// decided at the end of q3 of the compare cycle itself
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			skip_left <= 2'h0;
			skip_taken <= 1'b0;
			squash <= 1'b0;
		end else if (ph == CSBA_Q3 &&
			((op == CSBA_GT && cmp_gt) ||
			(op == CSBA_LT && cmp_lt))) begin
			skip_taken <= 1'b1; // RL15
			skip_left <= next_two_word ? `CSBA_SKIP_TWO :
				`CSBA_SKIP_ONE; // RL7
		end else if (ph == CSBA_Q3 &&
			(op == CSBA_GT || op == CSBA_LT)) begin
			skip_taken <= 1'b0; // RL6
		end else if (ph == CSBA_Q4) begin
			if (squash) begin
				squash <= (skip_left != `CSBA_SKIP_ONE); // RL7
				skip_left <= skip_left - `CSBA_SKIP_ONE;
			end else begin
				squash <= (skip_left != 2'h0); // RL6
			end
		end
	end

	// ----------------------------------------------------------------
	// result strobes
	// ----------------------------------------------------------------
	// only decimal adjust writes; compares touch no flag
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			working_register_wdata <= 8'h00;
			working_register_we <= 1'b0;
			carry_wdata <= 1'b0;
			carry_we <= 1'b0;
			last_w <= 8'h00;
		end else if (ph == CSBA_Q3 && op == CSBA_DAW) begin
			working_register_wdata <= adj_w; // RL13
			working_register_we <= 1'b1; // RL13
			carry_wdata <= adj_c; // RL14
			carry_we <= 1'b1; // RL14
			last_w <= adj_w;
		end else begin
			working_register_we <= 1'b0; // RL5
			carry_we <= 1'b0; // RL5
		end
	end

	// ----------------------------------------------------------------
	// apb slave
	// ----------------------------------------------------------------
	// one wait state: pready rises in the second access cycle
	assign acc = apb_req.psel && apb_req.penable;
	assign wr_hit = acc && apb_rsp.pready && apb_req.pwrite;

	always_comb begin
		rd_word = 32'h0000_0000;
		rd_ok = 1'b1;
		case (apb_req.paddr)
		`CSBA_CTRL_OFF: rd_word[`CSBA_CTRL_EXT_BIT] = ext_en;
		`CSBA_BANK_OFF: begin
			rd_word[`CSBA_BANK_LSB +: `CSBA_BANK_W] =
				bank_select_register;
		end
		`CSBA_STAT_OFF: begin
			rd_word[`CSBA_STAT_SQ_BIT] = squash;
			rd_word[`CSBA_STAT_TAKEN_BIT] = skip_taken;
			rd_word[`CSBA_STAT_LEFT_LSB +: 2] = skip_left;
			rd_word[`CSBA_STAT_W_LSB +: 8] = last_w;
		end
		default: rd_ok = 1'b0;
		endcase
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			apb_rsp <= '0;
		end else if (acc && !apb_rsp.pready) begin
			apb_rsp.pready <= 1'b1;
			apb_rsp.pslverr <= !rd_ok;
			apb_rsp.prdata <= apb_req.pwrite ? 32'h0000_0000 : rd_word;
		end else begin
			apb_rsp <= '0;
		end
	end

	// writable control; status is read only
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ext_en <= `CSBA_EXT_RST;
			bank_select_register <= `CSBA_BANK_RST;
		end else if (wr_hit) begin
			if (apb_req.paddr == `CSBA_CTRL_OFF) begin
				ext_en <= apb_req.pwdata[`CSBA_CTRL_EXT_BIT];
			end
			if (apb_req.paddr == `CSBA_BANK_OFF) begin
				bank_select_register <=
					apb_req.pwdata[`CSBA_BANK_LSB +: `CSBA_BANK_W];
			end
		end
	end
endmodule

// File: src/csba_pkg.sv
// Purpose: types shared by the compare-skip and decimal-adjust unit
// Assumes: nothing beyond the constants header
// Notes: phases and operations are one-hot
package csba_pkg;
	// ----------------------------------------------------------------
	// bus carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} csba_apb_req_t;
	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} csba_apb_rsp_t;
	// ----------------------------------------------------------------
	// sequencing
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		CSBA_Q1 = 4'b0001,
		CSBA_Q2 = 4'b0010,
		CSBA_Q3 = 4'b0100,
		CSBA_Q4 = 4'b1000
	} csba_phase_t;
	typedef enum logic [3:0] {
		CSBA_NONE = 4'b0001,
		CSBA_GT = 4'b0010,
		CSBA_LT = 4'b0100,
		CSBA_DAW = 4'b1000
	} csba_op_t;
endpackage

// File: src/csba_regs.svh
// Purpose: constants for the compare-skip and decimal-adjust unit
// Assumes: included by bare name, definitions only
// Notes: offsets are APB byte addresses
`ifndef CSBA_REGS_SVH
`define CSBA_REGS_SVH
// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define CSBA_CTRL_OFF 12'h000
`define CSBA_BANK_OFF 12'h004
`define CSBA_STAT_OFF 12'h008
`define CSBA_CTRL_EXT_BIT 0
`define CSBA_CTRL_RST 32'h0000_0000
`define CSBA_EXT_RST 1'b0
`define CSBA_BANK_LSB 0
`define CSBA_BANK_W 4
`define CSBA_BANK_RST 4'h0
`define CSBA_STAT_SQ_BIT 0
`define CSBA_STAT_TAKEN_BIT 1
`define CSBA_STAT_LEFT_LSB 2
`define CSBA_STAT_W_LSB 8
// ----------------------------------------------------------------
// instruction encodings and datapath constants
// ----------------------------------------------------------------
`define CSBA_OP_GT 7'h32
`define CSBA_OP_LT 7'h30
`define CSBA_OP_DAW 16'h0007
`define CSBA_ACC_SPLIT 8'h60
`define CSBA_IDX_MAX 8'h5f
`define CSBA_ACC_HIGH 4'hf
`define CSBA_BCD_MAX 5'h09
`define CSBA_BCD_FIX 5'h06
`define CSBA_LO_MAX 4'h9
`define CSBA_LO_FIX 4'h6
`define CSBA_SKIP_ONE 2'h1
`define CSBA_SKIP_TWO 2'h2
`endif

// File: tb/csba_core_assertions.sv
// Purpose: port-level temporal checks for csba_core
// Assumes: one clock domain, reset active high
// Notes: bound into every csba_core instance
`timescale 1ns/1ps
module csba_core_assertions (
	input wire logic sys_clk, // core clock
	input wire logic sys_rst, // async reset, high
	input wire csba_pkg::csba_apb_req_t apb_req, // apb request
	input wire csba_pkg::csba_apb_rsp_t apb_rsp, // apb answer
	input wire logic file_rd, // file read strobe
	input wire logic working_register_we, // W write strobe
	input wire logic carry_we, // carry write strobe
	input wire logic squash // discarded cycle
);
	import csba_pkg::*;
	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (sys_rst);
	// a skip must come from a compare read three clocks before
	a_skip_cause: assert property ($rose(squash) |-> $past(file_rd, 3))
		else $error("squash rose with no compare read before it");
	a_skip_len: assert property ($rose(squash) |-> squash [*4])
		else $error("skipped cycle shorter than four clocks");
	a_skip_max: assert property ($rose(squash) |-> ##[4:8] !squash)
		else $error("skip lasted more than two cycles");
	a_skip_quiet: assert property (squash |->
		!working_register_we && !carry_we && !file_rd)
		else $error("write or read during a skipped cycle");
	a_cmp_flags: assert property (file_rd |-> ##2 !carry_we)
		else $error("compare wrote a flag");
	a_adj_pair: assert property (working_register_we |-> carry_we)
		else $error("W written without carry");
	a_adj_once: assert property (working_register_we |=> !working_register_we [*3])
		else $error("W written twice in one cycle");
	a_rd_once: assert property (file_rd |=> !file_rd [*3])
		else $error("file read twice in one cycle");
	a_apb_wait: assert property (apb_req.psel && apb_req.penable
		&& !apb_rsp.pready |=> apb_rsp.pready)
		else $error("apb answer not after one wait state");
	a_apb_pulse: assert property (apb_rsp.pready |=> !apb_rsp.pready)
		else $error("pready held past one cycle");
	a_apb_err: assert property (apb_rsp.pslverr |-> apb_rsp.pready)
		else $error("pslverr without pready");
	// main scenarios reached
	c_skip_one: cover property ($rose(squash) ##4 !squash);
	c_skip_two: cover property (squash [*8]);
	c_adjust: cover property (working_register_we);
	c_apb_err: cover property (apb_rsp.pslverr);
endmodule
bind csba_core csba_core_assertions csba_core_assertions_i (
	.sys_clk(sys_clk),
	.sys_rst(sys_rst),
	.apb_req(apb_req),
	.apb_rsp(apb_rsp),
	.file_rd(file_rd),
	.working_register_we(working_register_we),
	.carry_we(carry_we),
	.squash(squash)
);

// File: tb/tb.sv
// Purpose: self-checking bench for csba_core
// Assumes: first Q1 starts at the reset release edge, 4 clocks a cycle
// Notes: address tests realign to the phase output after the apb tests
`timescale 1ns/1ps
module tb;
	import csba_pkg::*;
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	csba_apb_req_t req = '0;
	csba_apb_rsp_t rsp;
	logic iv = 1'b0;
	logic [15:0] word = 16'h0000;
	logic two = 1'b0;
	logic [7:0] wv = 8'h00;
	logic [7:0] fv = 8'h00;
	logic cin = 1'b0;
	logic dcin = 1'b0;
	logic [3:0] phase;
	logic file_rd, working_register_we, carry_wdata, carry_we, squash;
	logic [7:0] working_register_wdata;
	logic [8:0] n_sq, n_rd, n_we, got_w;
	logic [7:0] last_w;
	logic [11:0] file_addr, got_a;
	logic [15:0] ph_seq;
	logic [31:0] rd;
	logic err, sk;
	logic [4:0] h;
	logic [3:0] lo;
	int miscompares = 0;
	int compares = 0;
	logic [17:0] tab [0:9] = '{{2'b10, 16'h2020}, {2'b10, 16'h2120},
		{2'b10, 16'hff00}, {2'b10, 16'h7f80}, {2'b00, 16'h2020},
		{2'b00, 16'h1f20}, {2'b00, 16'h00ff}, {2'b11, 16'hfffe},
		{2'b01, 16'h0102}, {2'b11, 16'h1020}};

	csba_core csba_core_i (.sys_clk(sys_clk), .sys_rst(sys_rst),
		.apb_req(req), .apb_rsp(rsp), .instr_valid(iv), .instr_word(word),
		.next_two_word(two), .working_register(wv), .carry_in(cin),
		.digit_carry_flag(dcin), .index_base(12'h080), .file_rdata(fv),
		.phase(phase), .file_addr(file_addr), .file_rd(file_rd),
		.working_register_wdata(working_register_wdata), .working_register_we(working_register_we),
		.carry_wdata(carry_wdata), .carry_we(carry_we), .squash(squash));

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task chk(input logic [8:0] got, input logic [8:0] exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task chk32(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED %0t: bus %h want %h", $time, got, exp);
		end
	endtask
	// one instruction cycle, entered at a rising edge; counts strobes
	task slot(input logic v, input logic [15:0] wd, input logic [7:0] f,
		input logic [7:0] w);
		iv <= v;
		word <= wd;
		fv <= f;
		wv <= w;
		n_sq = 9'd0;
		n_rd = 9'd0;
		n_we = 9'd0;
		got_w = 'x;
		got_a = 'x;
		repeat (4) begin
			#1;
			ph_seq = {phase, ph_seq[15:4]};
			if (file_rd === 1'b1) got_a = file_addr;
			n_sq = n_sq + squash;
			n_rd = n_rd + file_rd;
			n_we = n_we + working_register_we + carry_we;
			if (working_register_we === 1'b1) got_w = {carry_wdata, working_register_wdata};
			@(posedge sys_clk);
		end
	endtask
	// a decimal-adjust word in the following slot must be swallowed when the compare skips
	task cmp(input logic [17:0] t);
		sk = t[17] ? t[15:8] > t[7:0] : t[15:8] < t[7:0];
		two <= t[16];
		slot(1'b1, {t[17] ? 7'h32 : 7'h30, t[8], 8'h20}, t[15:8], t[7:0]);
		chk(n_sq, 9'd0);
		chk(n_rd, 9'd1);
		chk(n_we, 9'd0);
		slot(1'b1, 16'h0007, 8'h00, 8'h00);
		chk(n_sq, sk ? 9'd4 : 9'd0);
		if (sk) chk(n_we, 9'd0);
		if (sk && t[16]) slot(1'b1, 16'h0007, 8'h00, 8'h00);
		if (sk && t[16]) chk(n_sq, 9'd4);
	endtask
	task decimal_adjust_working(input logic [7:0] w, input logic c, input logic d);
		lo = (w[3:0] > 4'h9 || d) ? w[3:0] + 4'h6 : w[3:0];
		h = w[7:4] + d;
		if (h > 5'h09 || c) h = h + 5'h06;
		cin <= c;
		dcin <= d;
		slot(1'b1, 16'h0007, 8'h00, w);
		chk(n_we, 9'd2);
		chk32({16'h0000, ph_seq}, 32'h0000_8421);
		chk(got_w, {c | h[4], h[3:0], lo});
		last_w = {h[3:0], lo};
	endtask
	// waits as long as it takes; only the watchdog ends a hang
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		req <= '{1'b1, 1'b0, wr, a, d};
		@(posedge sys_clk);
		req.penable <= 1'b1;
		do begin
			@(posedge sys_clk);
		end while (rsp.pready !== 1'b1);
		rd = rsp.prdata;
		err = rsp.pslverr;
		req <= '0;
		@(posedge sys_clk);
	endtask
	// land on the edge that starts q1, using the phase output
	task sync;
		do begin
			@(posedge sys_clk);
			#1;
		end while (phase !== 4'b1000);
		@(posedge sys_clk);
	endtask
	// one compare slot with no skip; checks the file address in q2
	task adr(input logic [15:0] wd, input logic [11:0] exp);
		slot(1'b1, wd, 8'h00, 8'h00);
		chk32({20'h00000, got_a}, {20'h00000, exp});
	endtask
	task wrap_up;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask

	// ----------------------------------------
	// clock, watchdog, tests
	// ----------------------------------------
	initial begin
		forever #5 sys_clk = ~sys_clk;
	end
	// the tests need about 44 cycles (about 175 clocks); far more means a hang
	initial begin
		#20000;
		miscompares++;
		wrap_up;
	end
	initial begin
		repeat (5) @(posedge sys_clk);
		sys_rst <= 1'b0;
		for (int i = 0; i < 10; i++) cmp(tab[i]);
		slot(1'b1, 16'h6620, 8'h30, 8'h10);
		chk(n_rd, 9'd0);
		$display("compare tests done");
		decimal_adjust_working(8'ha5, 1'b0, 1'b0);
		decimal_adjust_working(8'h09, 1'b0, 1'b1);
		decimal_adjust_working(8'h45, 1'b1, 1'b0);
		decimal_adjust_working(8'h99, 1'b0, 1'b0);
		decimal_adjust_working(8'h9a, 1'b0, 1'b0);
		slot(1'b0, 16'h0000, 8'h00, 8'h00);
		$display("adjust tests done");
		apb(1'b0, 12'h000, 32'h0);
		chk32(rd, 32'h0);
		apb(1'b1, 12'h004, 32'h5);
		apb(1'b0, 12'h004, 32'h0);
		chk32(rd, 32'h5);
		apb(1'b1, 12'h000, 32'h1);
		apb(1'b0, 12'h000, 32'h0);
		chk32(rd, 32'h1);
		apb(1'b0, 12'h00c, 32'h0);
		chk32({rd[30:0], err}, 32'h1);
		apb(1'b0, 12'h008, 32'h0);
		chk32({rd[15:8], rd[0]}, {last_w, 1'b0});
		$display("register tests done");
		sync;
		adr(16'h6420, 12'h0a0);
		adr(16'h6020, 12'h020);
		adr(16'h6070, 12'hf70);
		adr(16'h6534, 12'h534);
		adr(16'h6460, 12'hf60);
		$display("address tests done");
		wrap_up;
	end
endmodule
